// File: src/ext_port_defs.svh
// Constants for the external media-independent port: strap levels,
// layout of the words that cross between clock domains, line codes.
// Included by bare name from the package and the top module.
`ifndef EXT_PORT_DEFS_SVH
`define EXT_PORT_DEFS_SVH

// ----------------------------------------
// Strap levels that select the external port
// ----------------------------------------
`define EXT_STRAP0_SEL 1'b1
`define EXT_STRAP1_SEL 1'b0

// ----------------------------------------
// Crossing word layout: byte in [7:0], flags above
// ----------------------------------------
`define EXT_W_LAST 8
`define EXT_W_ERR 9
`define EXT_W_EXT 10
`define EXT_RX_W 10
`define EXT_TX_W 11

// ----------------------------------------
// Line codes
// ----------------------------------------
`define EXT_IDLE_CODE 8'h00
`define EXT_CARRIER_EXT_CODE 8'h0F
`define EXT_NIB_HOLD 4'h0

`endif

// File: src/ext_port_pkg.sv
// State types of the external media-independent port.
// Assumes the constants header sits on the include path.
`default_nettype none
`include "ext_port_defs.svh"

package ext_port_pkg;

	// ----------------------------------------
	// Transmit sequencer
	// ----------------------------------------
	typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;

	typedef struct packed {
		tx_state_t state;
		logic [7:0] cur;
		logic cur_last;
		logic nib_hi;
		logic [7:0] dout;
		logic en;
		logic er;
		logic gtx_run;
	} tx_st_t;

	// ----------------------------------------
	// Receive assembler and system-side status
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] din;
		logic dv;
		logic er;
		logic in_frame;
		logic [3:0] lo_nib;
		logic hi_phase;
		logic [7:0] held;
		logic held_vld;
		logic err;
		logic push;
		logic [`EXT_RX_W-1:0] push_data;
	} rx_st_t;

	typedef struct packed {
		logic strap_done;
		logic ext_mode;
		logic col;
		logic crs;
		logic link_up;
		logic mdio_en;
	} sys_st_t;

endpackage

`default_nettype wire

// File: src/bit_sync.sv
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a level that may be sampled at any time.
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_st_t;

	sync_st_t st_q;
	sync_st_t st_d;

	// First stage feeds only the second one
	always_comb
	begin
		st_d.s1 = async_i;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge clk_i)
	begin
		st_q <= st_d;
	end

	assign sync_o = st_q.s2;

endmodule

`default_nettype wire

// File: src/word_handoff.sv
// Toggle handshake that moves one word between two clock domains.
// Assumes each side has a synchronous reset of its own domain.
`timescale 1ns/1ps
`default_nettype none

module word_handoff #(
	parameter int W = 8
) (
	input wire logic clk_src_i,
	input wire logic rst_src_i,
	input wire logic src_valid_i,
	input wire logic [W-1:0] src_data_i,
	output logic src_ready_o,
	input wire logic clk_dst_i,
	input wire logic rst_dst_i,
	input wire logic dst_ready_i,
	output logic dst_valid_o,
	output logic [W-1:0] dst_data_o
);

	typedef struct packed {
		logic [W-1:0] data;
		logic req;
		logic ready;
	} src_st_t;

	typedef struct packed {
		logic [W-1:0] data;
		logic ack;
		logic full;
	} dst_st_t;

	src_st_t src_q;
	src_st_t src_d;
	dst_st_t dst_q;
	dst_st_t dst_d;
	logic ack_s;
	logic req_s;

	bit_sync #(.W(1)) u_ack_sync (.clk_i(clk_src_i), .async_i(dst_q.ack), .sync_o(ack_s));
	bit_sync #(.W(1)) u_req_sync (.clk_i(clk_dst_i), .async_i(src_q.req), .sync_o(req_s));

	// Source: data held still until the toggle comes back
	always_comb
	begin
		src_d = src_q;
		if (src_valid_i && src_q.ready)
		begin
			src_d.data = src_data_i;
			src_d.req = ~src_q.req;
			src_d.ready = 1'b0;
		end
		else
			src_d.ready = (ack_s == src_q.req);
		if (rst_src_i)
		begin
			src_d = '0;
			src_d.ready = 1'b1;
		end
	end

	// Destination: data is stable once the toggle is seen, so no sync
	always_comb
	begin
		dst_d = dst_q;
		if (dst_q.full && dst_ready_i)
		begin
			dst_d.full = 1'b0;
			dst_d.ack = req_s;
		end
		else if (!dst_q.full && (req_s != dst_q.ack))
		begin
			dst_d.data = src_q.data;
			dst_d.full = 1'b1;
		end
		if (rst_dst_i)
			dst_d = '0;
	end

	always_ff @(posedge clk_src_i)
	begin
		src_q <= src_d;
	end

	always_ff @(posedge clk_dst_i)
	begin
		dst_q <= dst_d;
	end

	assign src_ready_o = src_q.ready;
	assign dst_valid_o = dst_q.full;
	assign dst_data_o = dst_q.data;

endmodule

`default_nettype wire

// File: src/ext_gmii_port.sv
// External media-independent port, MAC side: byte stream in and out
// on the system clock, GMII or MII pins on the link clocks.
// Assumes tx_clk_i is the 125 MHz reference in gigabit mode and the
// PHY nibble transmit clock in 10/100 mode; rx_clk_i comes from the PHY.
`timescale 1ns/1ps
`default_nettype none
`include "ext_port_defs.svh"

// Overview of operation
// RL1 - Route internal MAC link to external pins
// RL2 - Board straps: first high, second low
// RL3 - Gigabit transmit: one byte per clock
// RL4 - TX_EN high only while sending frame data
// RL5 - TX_ER marks errors and carrier extension
// RL6 - 10/100 transmit on four-bit nibble bus
// RL7 - 10/100 mode never uses transmit error
// RL8 - GTX_CLK runs 125 MHz in gigabit only
// RL9 - Collision input from PHY for half-duplex
// RL10 - Carrier sense input from PHY
// RL11 - Gigabit receive: one byte per clock
// RL12 - 10/100 receive: one nibble per clock
// RL13 - Receive data accepted only with RX_DV
// RL14 - RX_ER marks the frame as errored
// RL15 - Link indication pin gives link up
// RL16 - No management interface in gigabit mode
// RL17 - Receive signals sampled on RX_CLK
// RL18 - 10/100 nibbles launched on PHY clock
// RL19 - Upper nibble quiet, low nibble first
module ext_gmii_port
	import ext_port_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic tx_clk_i,
	input wire logic rx_clk_i,
	input wire logic ext_if_strap0_i,
	input wire logic ext_if_strap1_i,
	input wire logic speed_gig_i,
	input wire logic mac_tx_valid_i,
	input wire logic [7:0] mac_tx_data_i,
	input wire logic mac_tx_last_i,
	input wire logic mac_tx_err_i,
	input wire logic mac_tx_ext_i,
	output logic mac_tx_ready_o,
	output logic mac_rx_valid_o,
	output logic [7:0] mac_rx_data_o,
	output logic mac_rx_last_o,
	output logic mac_rx_err_o,
	output logic col_o,
	output logic crs_o,
	output logic link_up_o,
	output logic ext_mode_o,
	output logic mdio_enable_o,
	output logic [7:0] tx_data_o,
	output logic tx_en_o,
	output logic tx_er_o,
	output logic gtx_clk_o,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_dv_i,
	input wire logic rx_er_i,
	input wire logic col_i,
	input wire logic crs_i,
	input wire logic link_indication_in_i
);

	// ----------------------------------------
	// System domain: straps and PHY status
	// ----------------------------------------
	sys_st_t sys_q;
	sys_st_t sys_d;
	logic [4:0] pin_s;
	logic col_s;
	logic crs_s;

	bit_sync #(.W(5)) u_pin_sync (
		.clk_i(clk_sys_i),
		.async_i({link_indication_in_i, crs_i, col_i, ext_if_strap1_i, ext_if_strap0_i}),
		.sync_o(pin_s)
	);

	assign col_s = pin_s[2];
	assign crs_s = pin_s[3];

	// Straps caught once after reset; sync chain fills during reset
	always_comb
	begin
		sys_d = sys_q;
		if (!sys_q.strap_done)
		begin
			sys_d.strap_done = 1'b1;
			sys_d.ext_mode = (pin_s[0] == `EXT_STRAP0_SEL) && (pin_s[1] == `EXT_STRAP1_SEL); // RL2 RL1
		end
		sys_d.col = sys_q.ext_mode & col_s; // RL9
		sys_d.crs = sys_q.ext_mode & crs_s; // RL10
		sys_d.link_up = sys_q.ext_mode & pin_s[4]; // RL15
		sys_d.mdio_en = !(sys_q.ext_mode && speed_gig_i); // RL16
		if (sys_rst_i)
		begin
			sys_d = '0;
			sys_d.mdio_en = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		sys_q <= sys_d;
	end

	assign col_o = sys_q.col;
	assign crs_o = sys_q.crs;
	assign link_up_o = sys_q.link_up;
	assign ext_mode_o = sys_q.ext_mode;
	assign mdio_enable_o = sys_q.mdio_en;

	a_mdio_off: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RL16
		sys_q.ext_mode && speed_gig_i |=> !mdio_enable_o)
		else $error("management port left on in gigabit mode");
	a_link_follow: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RL15
		sys_q.ext_mode && pin_s[4] |=> link_up_o)
		else $error("link indication not shown");
	a_col_follow: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RL9
		sys_q.ext_mode ##1 sys_q.ext_mode |-> col_o == $past(col_s))
		else $error("collision not forwarded");
	a_crs_follow: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RL10
		sys_q.ext_mode ##1 sys_q.ext_mode |-> crs_o == $past(crs_s))
		else $error("carrier sense not forwarded");

	// ----------------------------------------
	// Transmit domain
	// ----------------------------------------
	tx_st_t tx_q;
	tx_st_t tx_d;
	logic [2:0] tx_cfg;
	logic tx_rst;
	logic tx_ext;
	logic tx_gig;
	logic tx_hv;
	logic tx_take;
	logic [`EXT_TX_W-1:0] tx_hw;
	logic [7:0] tx_hbyte;
	logic [3:0] tx_hlo;
	logic [3:0] tx_hhi;
	logic gtx_gate_q;

	bit_sync #(.W(3)) u_tx_cfg (
		.clk_i(tx_clk_i),
		.async_i({speed_gig_i, sys_q.ext_mode, sys_rst_i}),
		.sync_o(tx_cfg)
	);

	assign tx_rst = tx_cfg[0];
	assign tx_ext = tx_cfg[1];
	assign tx_gig = tx_cfg[2];
	assign tx_hbyte = tx_hw[7:0];
	assign tx_hlo = tx_hw[3:0];
	assign tx_hhi = tx_hw[7:4];

	// One word in flight; the MAC waits on ready between words
	word_handoff #(.W(`EXT_TX_W)) u_tx_hand (
		.clk_src_i(clk_sys_i),
		.rst_src_i(sys_rst_i),
		.src_valid_i(mac_tx_valid_i & sys_q.ext_mode),
		.src_data_i({mac_tx_ext_i, mac_tx_err_i, mac_tx_last_i, mac_tx_data_i}),
		.src_ready_o(mac_tx_ready_o),
		.clk_dst_i(tx_clk_i),
		.rst_dst_i(tx_rst),
		.dst_ready_i(tx_take),
		.dst_valid_o(tx_hv),
		.dst_data_o(tx_hw)
	);

	// Start a byte, or after the frame a carrier extension code in gigabit, idle code in 10/100
	function automatic tx_st_t tx_launch(tx_st_t s, logic [`EXT_TX_W-1:0] w, logic gig);
		tx_st_t r;
		r = s;
		r.cur = w[7:0];
		r.cur_last = w[`EXT_W_LAST];
		if (w[`EXT_W_EXT])
		begin
			r.dout = gig ? `EXT_CARRIER_EXT_CODE : `EXT_IDLE_CODE;
			r.en = 1'b0;
			r.er = gig; // RL5
			r.state = TX_IDLE;
		end
		else if (gig)
		begin
			r.dout = w[7:0]; // RL3
			r.en = 1'b1; // RL4
			r.er = w[`EXT_W_ERR]; // RL5
			r.state = w[`EXT_W_LAST] ? TX_IDLE : TX_SEND;
		end
		else
		begin
			r.dout = {`EXT_NIB_HOLD, w[3:0]}; // RL6 RL19
			r.en = 1'b1;
			r.er = 1'b0; // RL7
			r.nib_hi = 1'b1;
			r.state = TX_SEND;
		end
		return r;
	endfunction

	// A late word mid-frame is an underrun: gigabit flags it, MII truncates
	always_comb
	begin
		tx_d = tx_q;
		tx_take = 1'b0;
		tx_d.gtx_run = tx_gig & tx_ext; // RL8
		case (tx_q.state)
			TX_IDLE:
			begin
				tx_d.dout = `EXT_IDLE_CODE;
				tx_d.en = 1'b0;
				tx_d.er = 1'b0;
				if (tx_hv)
				begin
					tx_take = 1'b1;
					tx_d = tx_launch(tx_d, tx_hw, tx_gig);
				end
			end
			TX_SEND:
			begin
				if (!tx_gig && tx_q.nib_hi)
				begin
					tx_d.dout = {`EXT_NIB_HOLD, tx_q.cur[7:4]}; // RL19 RL18
					tx_d.en = 1'b1;
					tx_d.er = 1'b0;
					tx_d.nib_hi = 1'b0;
					if (tx_q.cur_last)
						tx_d.state = TX_IDLE;
				end
				else if (tx_hv)
				begin
					tx_take = 1'b1;
					tx_d = tx_launch(tx_d, tx_hw, tx_gig);
				end
				else
				begin
					tx_d.dout = `EXT_IDLE_CODE;
					tx_d.en = tx_gig;
					tx_d.er = tx_gig; // RL5 RL7
					tx_d.state = TX_IDLE;
				end
			end
			default:
				tx_d.state = TX_IDLE;
		endcase
		if (tx_rst || !tx_ext)
		begin
			tx_d = '0;
			tx_take = 1'b0;
		end
	end

	always_ff @(posedge tx_clk_i)
	begin
		tx_q <= tx_d;
	end

	// Gate changes on the low phase so the forwarded clock has no runts
	always_ff @(negedge tx_clk_i)
	begin
		gtx_gate_q <= tx_q.gtx_run;
	end

	assign gtx_clk_o = tx_clk_i & gtx_gate_q; // RL8
	assign tx_data_o = tx_q.dout;
	assign tx_en_o = tx_q.en;
	assign tx_er_o = tx_q.er;

	sequence s_gig_take;
		tx_take && tx_gig && !tx_hw[`EXT_W_EXT];
	endsequence
	sequence s_ext_take;
		tx_take && tx_gig && tx_hw[`EXT_W_EXT];
	endsequence
	sequence s_mii_take;
		tx_take && !tx_gig && !tx_hw[`EXT_W_EXT];
	endsequence

	a_gig_byte_out: assert property (@(posedge tx_clk_i) disable iff (tx_rst) // RL3
		s_gig_take |=> tx_en_o && tx_data_o == $past(tx_hbyte))
		else $error("gigabit byte not launched");
	a_ext_code: assert property (@(posedge tx_clk_i) disable iff (tx_rst) // RL5
		s_ext_take |=> !tx_en_o && tx_er_o && tx_data_o == `EXT_CARRIER_EXT_CODE)
		else $error("carrier extension code wrong");
	a_nibble_pair: assert property (@(posedge tx_clk_i) disable iff (tx_rst || tx_gig) // RL6
		s_mii_take |=> (tx_en_o && tx_data_o[3:0] == $past(tx_hlo))
		##1 (tx_en_o && tx_data_o[3:0] == $past(tx_hhi, 2)))
		else $error("nibble order wrong");
	a_mii_upper: assert property (@(posedge tx_clk_i) disable iff (tx_rst) // RL19
		!tx_q.gtx_run |-> tx_data_o[7:4] == `EXT_NIB_HOLD)
		else $error("upper nibble not quiet");
	a_mii_no_er: assert property (@(posedge tx_clk_i) disable iff (tx_rst) // RL7
		!tx_gig ##1 !tx_gig |-> !tx_er_o)
		else $error("transmit error used in 10/100 mode");

	// ----------------------------------------
	// Receive domain
	// ----------------------------------------
	rx_st_t rx_q;
	rx_st_t rx_d;
	logic [2:0] rx_cfg;
	logic rx_rst;
	logic rx_ext;
	logic rx_gig;
	logic rx_rdy;
	logic rx_byte_rdy;
	logic [7:0] rx_nb;
	logic [`EXT_RX_W-1:0] rx_word;

	bit_sync #(.W(3)) u_rx_cfg (
		.clk_i(rx_clk_i),
		.async_i({speed_gig_i, sys_q.ext_mode, sys_rst_i}),
		.sync_o(rx_cfg)
	);

	assign rx_rst = rx_cfg[0];
	assign rx_ext = rx_cfg[1];
	assign rx_gig = rx_cfg[2];

	word_handoff #(.W(`EXT_RX_W)) u_rx_hand (
		.clk_src_i(rx_clk_i),
		.rst_src_i(rx_rst),
		.src_valid_i(rx_q.push),
		.src_data_i(rx_q.push_data),
		.src_ready_o(rx_rdy),
		.clk_dst_i(clk_sys_i),
		.rst_dst_i(sys_rst_i),
		.dst_ready_i(1'b1),
		.dst_valid_o(mac_rx_valid_o),
		.dst_data_o(rx_word)
	);

	assign mac_rx_data_o = rx_word[7:0];
	assign mac_rx_last_o = rx_word[`EXT_W_LAST];
	assign mac_rx_err_o = rx_word[`EXT_W_ERR];

	// One byte is held back so the last one can carry the end mark
	always_comb
	begin
		rx_d = rx_q;
		rx_byte_rdy = 1'b0;
		rx_nb = rx_q.din;
		rx_d.push = 1'b0;
		rx_d.din = rx_data_i; // RL17
		rx_d.dv = rx_dv_i;
		rx_d.er = rx_er_i;
		if (rx_q.push && !rx_rdy && (rx_q.dv || rx_q.in_frame))
			rx_d.err = 1'b1; // Overrun only marks a frame still open
		if (rx_q.dv) // RL13
		begin
			if (rx_q.er)
				rx_d.err = 1'b1; // RL14
			if (rx_gig)
				rx_byte_rdy = 1'b1; // RL11
			else if (rx_q.hi_phase)
			begin
				rx_nb = {rx_q.din[3:0], rx_q.lo_nib}; // RL12 RL19
				rx_byte_rdy = 1'b1;
				rx_d.hi_phase = 1'b0;
			end
			else
			begin
				rx_d.lo_nib = rx_q.din[3:0];
				rx_d.hi_phase = 1'b1;
			end
			if (rx_byte_rdy)
			begin
				rx_d.push = rx_q.held_vld;
				rx_d.push_data = {rx_d.err, 1'b0, rx_q.held};
				rx_d.held = rx_nb;
				rx_d.held_vld = 1'b1;
			end
		end
		else if (rx_q.in_frame)
		begin
			rx_d.push = rx_q.held_vld;
			rx_d.push_data = {rx_d.err | rx_q.hi_phase, 1'b1, rx_q.held}; // RL14
			rx_d.held_vld = 1'b0;
			rx_d.err = 1'b0;
			rx_d.hi_phase = 1'b0;
		end
		rx_d.in_frame = rx_q.dv;
		if (rx_rst || !rx_ext)
			rx_d = '0;
	end

	always_ff @(posedge rx_clk_i)
	begin
		rx_q <= rx_d;
	end

	a_rx_only_dv: assert property (@(posedge rx_clk_i) disable iff (rx_rst) // RL13
		!rx_q.dv && !rx_q.in_frame |=> !rx_q.push)
		else $error("receive push outside a frame");
	a_rx_err_mark: assert property (@(posedge rx_clk_i) disable iff (rx_rst) // RL14
		rx_ext && rx_q.dv && rx_q.er |=> rx_q.err || !rx_ext)
		else $error("receive error not recorded");

endmodule

`default_nettype wire

// File: dv/phy_model.sv
// Behavioural external PHY: both link clocks, receive beats, transmit capture.
// Assumes the bench queues receive beats and reads back the capture queue.
`timescale 1ns/1ps
`default_nettype none

module phy_model (
	output logic tx_clk_o,
	output logic rx_clk_o,
	output logic [7:0] rx_data_o,
	output logic rx_dv_o,
	output logic rx_er_o,
	input wire logic [7:0] tx_data_i,
	input wire logic tx_en_i,
	input wire logic tx_er_i
);
	// ----------------------------------------
	// Queues, beat layout {er, dv, data}
	// ----------------------------------------
	logic [9:0] rx_beats[$];
	logic [9:0] tx_seen[$];

	// Link clocks run free at 125 ns, phases unrelated to the system clock
	initial
	begin
		tx_clk_o = 1'b0;
		rx_clk_o = 1'b0;
		rx_data_o = 8'h5A;
		rx_dv_o = 1'b0;
		rx_er_o = 1'b0;
		#41;
		forever #62.5 rx_clk_o = ~rx_clk_o;
	end

	// Transmit clock supplied by the far side
	always #62.5 tx_clk_o = ~tx_clk_o;

	// Receive beats launched after the edge; idle data toggles so stale bytes never look valid
	always @(posedge rx_clk_o)
	begin
		#1;
		if (rx_beats.size() != 0)
			{rx_er_o, rx_dv_o, rx_data_o} = rx_beats.pop_front();
		else
		begin
			rx_dv_o = 1'b0;
			rx_er_o = 1'b0;
			rx_data_o = ~rx_data_o;
		end
	end

	// Capture every transmit cycle that carries enable or error
	always @(posedge tx_clk_o)
		if (tx_en_i || tx_er_i)
			tx_seen.push_back({tx_er_i, tx_en_i, tx_data_i});
endmodule
`default_nettype wire

// File: dv/external_gmii_mii_port_test.sv
// Self-checking bench for the external media-independent port.
// Assumes the PHY model supplies both link clocks and captures transmit cycles.
`timescale 1ns/1ps
`default_nettype none

module external_gmii_mii_port_test;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk_sys_i, sys_rst_i, speed_gig_i, mac_tx_valid_i, mac_tx_last_i, mac_tx_err_i, mac_tx_ext_i;
	logic [7:0] mac_tx_data_i, mac_rx_data_o, tx_data_o, rx_data_i, d, r;
	logic mac_tx_ready_o, mac_rx_valid_o, mac_rx_last_o, mac_rx_err_o, col_o, crs_o, link_up_o, ext_mode_o;
	logic mdio_enable_o, tx_en_o, tx_er_o, gtx_clk_o, tx_clk_i, rx_clk_i, rx_dv_i, rx_er_i;
	logic col_i, crs_i, link_indication_in_i, ext_if_strap0_i, ext_if_strap1_i, e, x;
	logic [2:0] st;
	logic [9:0] rxq[$];
	int err_total, checks_done, cyc, seed, gtx_n, i;

	ext_gmii_port dut (.clk_sys_i, .sys_rst_i, .tx_clk_i, .rx_clk_i, .ext_if_strap0_i, .ext_if_strap1_i,
		.speed_gig_i, .mac_tx_valid_i, .mac_tx_data_i, .mac_tx_last_i, .mac_tx_err_i, .mac_tx_ext_i,
		.mac_tx_ready_o, .mac_rx_valid_o, .mac_rx_data_o, .mac_rx_last_o, .mac_rx_err_o, .col_o, .crs_o,
		.link_up_o, .ext_mode_o, .mdio_enable_o, .tx_data_o, .tx_en_o, .tx_er_o, .gtx_clk_o, .rx_data_i,
		.rx_dv_i, .rx_er_i, .col_i, .crs_i, .link_indication_in_i);

	phy_model phy (.tx_clk_o(tx_clk_i), .rx_clk_o(rx_clk_i), .rx_data_o(rx_data_i), .rx_dv_o(rx_dv_i),
		.rx_er_o(rx_er_i), .tx_data_i(tx_data_o), .tx_en_i(tx_en_o), .tx_er_i(tx_er_o));

	// ----------------------------------------
	// Clock, timeout and monitors
	// ----------------------------------------
	initial clk_sys_i = 1'b0;
	always #10 clk_sys_i = ~clk_sys_i;

	// Cut a hang short well above the expected run length
	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			summarize();
		end
	end

	// Collect received bytes as {err, last, data}
	always @(posedge clk_sys_i)
		if (mac_rx_valid_o === 1'b1)
			rxq.push_back({mac_rx_err_o, mac_rx_last_o, mac_rx_data_o});

	// Count gigabit clock edges leaving the pin
	always @(posedge gtx_clk_o)
		gtx_n++;

	// ----------------------------------------
	// Tasks and expectation functions
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask

	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("err_total=%0d checks_done=%0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Offer one word and hold it until taken at a ready edge
	task automatic send_word(input logic [7:0] dt, input logic er, input logic ex);
		int k;
		k = 0;
		mac_tx_valid_i = 1'b1;
		mac_tx_data_i = dt;
		mac_tx_err_i = er;
		mac_tx_ext_i = ex;
		mac_tx_last_i = ~ex;
		@(posedge clk_sys_i);
		while (mac_tx_ready_o !== 1'b1 && k < 500)
		begin
			k++;
			@(posedge clk_sys_i);
		end
		#1;
		if (k == 500)
			err_total++;
		mac_tx_valid_i = 1'b0;
	endtask

	// Expected capture: extension code, full byte, or one nibble with quiet upper half
	function automatic logic [9:0] tx_exp(input logic gig, input logic [7:0] dt, input logic er,
		input logic ex, input logic hi);
		if (ex)
			return {2'b10, 8'h0F};
		if (gig)
			return {er, 1'b1, dt};
		return {2'b01, 4'h0, hi ? dt[7:4] : dt[3:0]};
	endfunction

	function automatic logic [9:0] pop_tx();
		return phy.tx_seen.size() != 0 ? phy.tx_seen.pop_front() : 10'h3FF;
	endfunction

	// Switch speed, then check management and the gated transmit clock
	task automatic set_speed(input logic gig);
		speed_gig_i = gig;
		tick(20);
		gtx_n = 0;
		tick(50);
		check(mdio_enable_o, !gig);
		check(gtx_n != 0, gig);
	endtask

	// Single-byte frames plus one extension word; in 10/100 mode it must leave the pins quiet
	task automatic tx_case(input logic gig);
		for (i = 0; i < 12; i++)
		begin
			d = (i == 0) ? 8'hFF : 8'($random(seed));
			e = 1'($random(seed));
			x = (i == 11);
			send_word(d, e, x);
			tick(70);
			if (gig || !x)
				check(pop_tx(), tx_exp(gig, d, e, x, 1'b0));
			if (!gig && !x)
				check(pop_tx(), tx_exp(gig, d, e, x, 1'b1));
			check(10'(phy.tx_seen.size()), 10'h000);
		end
	endtask

	// Single-byte frames, nibble beats carry junk in the upper half
	task automatic rx_case(input logic gig);
		for (i = 0; i < 12; i++)
		begin
			d = (i == 0) ? 8'h00 : 8'($random(seed));
			r = 8'($random(seed));
			e = (i % 4) == 3;
			if (gig)
				phy.rx_beats.push_back({e, 1'b1, d});
			else
			begin
				phy.rx_beats.push_back({e, 1'b1, r[7:4], d[3:0]});
				phy.rx_beats.push_back({e, 1'b1, r[3:0], d[7:4]});
			end
			tick(100);
			check(10'(rxq.size()), 10'h001);
			check(rxq.size() != 0 ? rxq.pop_front() : 10'h3FF, {e, 1'b1, d});
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		seed = 16;
		err_total = 0;
		checks_done = 0;
		cyc = 0;
		sys_rst_i = 1'b1;
		speed_gig_i = 1'b1;
		mac_tx_valid_i = 1'b0;
		mac_tx_data_i = 8'h00;
		mac_tx_last_i = 1'b0;
		mac_tx_err_i = 1'b0;
		mac_tx_ext_i = 1'b0;
		ext_if_strap0_i = 1'b1;
		ext_if_strap1_i = 1'b0;
		col_i = 1'b0;
		crs_i = 1'b0;
		link_indication_in_i = 1'b0;
		tick(40);
		check({mac_tx_ready_o, mdio_enable_o, tx_en_o, tx_er_o}, 10'h00C);
		sys_rst_i = 1'b0;
		tick(40);
		check(ext_mode_o, 1'b1);
		// Status pins follow the PHY after synchronising
		for (i = 0; i < 8; i++)
		begin
			st = (i == 0) ? 3'h7 : 3'($random(seed));
			{col_i, crs_i, link_indication_in_i} = st;
			tick(6);
			check({col_o, crs_o, link_up_o}, st);
		end
		set_speed(1'b1);
		tx_case(1'b1);
		rx_case(1'b1);
		set_speed(1'b0);
		tx_case(1'b0);
		rx_case(1'b0);
		summarize();
	end
endmodule
`default_nettype wire
